// File: hw/gstb_pkg.sv
// package: constants and carriers for the general strobe port
package gstb_pkg;
  // ---------------------------------------------------------------
  // isa addresses and indices
  // ---------------------------------------------------------------
  localparam logic [9:0] INDEX_PORT_ADDR = 10'h3e0;
  localparam logic [9:0] DATA_PORT_ADDR = 10'h3e1;
  localparam logic [7:0] SOCK_A_EXT_IDX_REG = 8'h2e;
  localparam logic [7:0] SOCK_A_EXT_DATA_REG = 8'h2f;
  localparam logic [7:0] SOCK_B_EXT_IDX_REG = 8'h6e;
  localparam logic [7:0] SOCK_B_EXT_DATA_REG = 8'h6f;
  localparam logic [7:0] EXT_PORT_DATA_IDX = 8'h0a;
  localparam logic [7:0] STROBE_CTRL_IDX = 8'h0b;
  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_ACT_HIGH_BIT = 5;
  localparam int CTRL_ON_WRITE_BIT = 4;
  localparam int CTRL_ON_READ_BIT = 3;
  localparam int CTRL_TOTEM_BIT = 2;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h3c;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic ior_n;
    logic iow_n;
    logic aen;
  } gstb_isa_t;
  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_en;
  } gstb_pin_t;
  typedef enum logic [1:0] {
    GSTB_IDLE = 2'b01,
    GSTB_BUSY = 2'b10
  } gstb_cyc_t;
endpackage

// File: hw/gstb_port.sv
// module: two-socket general strobe port with shadowed external data
//
// Summary of operation
// - each socket has a strobe control register at extended index 0bh
// - extended index written at 2e/6e selects the register seen at 2f/6f
// - control bit 5 selects active-high strobe, default active-low
// - bit 4 strobes for the whole iow low time on matching data writes
// - bit 3 strobes for the whole ior low time on matching data reads
// - pin is open-collector unless bit 2 makes it totem-pole
// - unconfigured pin is an input with pull-up unless disabled
// - write-strobe pin reads return the internal shadow
// - write-strobe mode writes update latch and shadow
// - read-strobe mode writes update shadow, reads return external data
// - strobes work in suspend but are blocked in super-suspend
// - strobe is combinational; shadow writes only when not suspended
`timescale 1ns/1ps
module gstb_port
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // isa bus, already synchronous to core_clk_i except the commands
  input wire logic [9:0] isa_addr_i,
  input wire logic [7:0] isa_wdata_i,
  input wire logic isa_ior_n_i,
  input wire logic isa_iow_n_i,
  input wire logic isa_aen_i,
  output logic [7:0] isa_rdata_o,
  output logic isa_rdata_oe_o,
  // external data bus seen through the read buffer
  input wire logic [7:0] ext_rdata_i,
  // power state and pull-up control
  input wire logic suspend_i,
  input wire logic [1:0] pullup_dis_i,
  // strobe pins, socket a then b
  input wire logic socket_a_strobe_i,
  input wire logic socket_b_strobe_i,
  output logic socket_a_strobe_o,
  output logic socket_a_strobe_oe_o,
  output logic socket_a_pullup_o,
  output logic socket_b_strobe_o,
  output logic socket_b_strobe_oe_o,
  output logic socket_b_pullup_o,
  // sampled level of the strobe pins
  output logic [1:0] strobe_pin_level_o
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] gstb_ext_reg(input logic s);
    return s ? gstb_pkg::SOCK_B_EXT_DATA_REG : gstb_pkg::SOCK_A_EXT_DATA_REG;
  endfunction

  function automatic logic [7:0] gstb_idx_reg(input logic s);
    return s ? gstb_pkg::SOCK_B_EXT_IDX_REG : gstb_pkg::SOCK_A_EXT_IDX_REG;
  endfunction

  // ---------------------------------------------------------------
  // command and pin synchronisers; commands used only for clocked register updates, pins only for strobe_pin_level_o
  // ---------------------------------------------------------------
  logic [1:0] ior_sync_reg;
  logic [1:0] iow_sync_reg;
  logic [1:0] pin_a_sync_reg;
  logic [1:0] pin_b_sync_reg;
  logic iow_prev_reg;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ior_sync_reg <= 2'h3;
      iow_sync_reg <= 2'h3;
      iow_prev_reg <= 1'b1;
      pin_a_sync_reg <= 2'h3;
      pin_b_sync_reg <= 2'h3;
    end
    else
    begin
      ior_sync_reg <= {ior_sync_reg[0], isa_ior_n_i};
      iow_sync_reg <= {iow_sync_reg[0], isa_iow_n_i};
      iow_prev_reg <= iow_sync_reg[1];
      pin_a_sync_reg <= {pin_a_sync_reg[0], socket_a_strobe_i};
      pin_b_sync_reg <= {pin_b_sync_reg[0], socket_b_strobe_i};
    end
  end
  assign strobe_pin_level_o = {pin_b_sync_reg[1], pin_a_sync_reg[1]};

  // commit on the rising edge of the write command, address still held
  logic wr_commit;
  assign wr_commit = iow_sync_reg[1] & ~iow_prev_reg & ~isa_aen_i;

  // ---------------------------------------------------------------
  // index and register state
  // ---------------------------------------------------------------
  logic [7:0] main_index_reg;
  logic [7:0] ext_index_reg [2];
  logic [7:0] ctrl_reg [2];
  logic [7:0] shadow_reg [2];
  logic at_index_port;
  logic at_data_port;
  assign at_index_port = isa_addr_i == gstb_pkg::INDEX_PORT_ADDR;
  assign at_data_port = isa_addr_i == gstb_pkg::DATA_PORT_ADDR;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      main_index_reg <= gstb_pkg::INDEX_RESET;
    else if (wr_commit && at_index_port)
      main_index_reg <= isa_wdata_i;
  end

  // per-socket decode of the current data port cycle
  logic [1:0] sel_ext;
  logic [1:0] sel_data;
  logic [1:0] sel_ctrl;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      sel_ext[s] = at_data_port && main_index_reg == gstb_ext_reg(1'(s));
      sel_data[s] = sel_ext[s] && ext_index_reg[s] == gstb_pkg::EXT_PORT_DATA_IDX;
      sel_ctrl[s] = sel_ext[s] && ext_index_reg[s] == gstb_pkg::STROBE_CTRL_IDX;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_sock
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
        ext_index_reg[g] <= gstb_pkg::INDEX_RESET;
      else if (wr_commit && at_data_port && main_index_reg == gstb_idx_reg(1'(g)))
        ext_index_reg[g] <= isa_wdata_i;
    end
    // strobe control, reserved bits kept zero
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
        ctrl_reg[g] <= gstb_pkg::CTRL_RESET;
      else if (wr_commit && sel_ctrl[g])
        ctrl_reg[g] <= isa_wdata_i & gstb_pkg::CTRL_WRITABLE_MASK;
    end
    // shadow only while clock is active
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
        shadow_reg[g] <= gstb_pkg::DATA_RESET;
      else if (wr_commit && sel_data[g] && !suspend_i)
        shadow_reg[g] <= isa_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // strobe generation, direct from the isa commands
  // ---------------------------------------------------------------
  logic [1:0] strobe_act;
  logic [1:0] strobe_lvl;
  logic [1:0] strobe_oe;
  logic [1:0] strobe_pu;
  logic super_suspend;
  // super-suspend is suspend with aen high
  assign super_suspend = suspend_i & isa_aen_i;
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      // strobe follows command; no clock in path
      strobe_act[s] = sel_data[s] && !super_suspend && !isa_aen_i &&
        ((ctrl_reg[s][gstb_pkg::CTRL_ON_WRITE_BIT] && !isa_iow_n_i) ||
         (ctrl_reg[s][gstb_pkg::CTRL_ON_READ_BIT] && !isa_ior_n_i));
      strobe_lvl[s] = strobe_act[s] ~^ ctrl_reg[s][gstb_pkg::CTRL_ACT_HIGH_BIT];
      // open-collector drives only the low level
      strobe_oe[s] = (ctrl_reg[s][gstb_pkg::CTRL_ON_WRITE_BIT] ||
                      ctrl_reg[s][gstb_pkg::CTRL_ON_READ_BIT]) &&
                     (ctrl_reg[s][gstb_pkg::CTRL_TOTEM_BIT] || !strobe_lvl[s]);
      // pull-up only as a reserved input
      strobe_pu[s] = !ctrl_reg[s][gstb_pkg::CTRL_ON_WRITE_BIT] &&
                     !ctrl_reg[s][gstb_pkg::CTRL_ON_READ_BIT] && !pullup_dis_i[s];
    end
  end
  assign socket_a_strobe_o = strobe_lvl[0];
  assign socket_b_strobe_o = strobe_lvl[1];
  assign socket_a_strobe_oe_o = strobe_oe[0];
  assign socket_b_strobe_oe_o = strobe_oe[1];
  assign socket_a_pullup_o = strobe_pu[0];
  assign socket_b_pullup_o = strobe_pu[1];

  // ---------------------------------------------------------------
  // readback mux; isa read data is a bus answer, drive only while ior low
  // ---------------------------------------------------------------
  always_comb
  begin
    isa_rdata_o = 8'h00;
    isa_rdata_oe_o = 1'b0;
    if (!isa_ior_n_i && !isa_aen_i)
    begin
      if (at_index_port)
      begin
        isa_rdata_o = main_index_reg;
        isa_rdata_oe_o = 1'b1;
      end
      for (int s = 0; s < 2; s++)
      begin
        if (at_data_port && main_index_reg == gstb_idx_reg(1'(s)))
        begin
          isa_rdata_o = ext_index_reg[s];
          isa_rdata_oe_o = 1'b1;
        end
        if (sel_ctrl[s])
        begin
          isa_rdata_o = ctrl_reg[s];
          isa_rdata_oe_o = 1'b1;
        end
        if (sel_data[s])
        begin
          isa_rdata_oe_o = 1'b1;
          // write-strobe reads give shadow; else external
          if (ctrl_reg[s][gstb_pkg::CTRL_ON_WRITE_BIT])
            isa_rdata_o = shadow_reg[s];
          else
            isa_rdata_o = ext_rdata_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ctrl_reserved_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ((ctrl_reg[0] | ctrl_reg[1]) & ~gstb_pkg::CTRL_WRITABLE_MASK) == 8'h00)
    else $error("reserved control bits set");
  ctrl_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_commit && sel_ctrl[1]) |=>
    ctrl_reg[1] == ($past(isa_wdata_i) & gstb_pkg::CTRL_WRITABLE_MASK))
    else $error("control write lost");
  ext_index_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_commit && at_data_port && main_index_reg == gstb_pkg::SOCK_A_EXT_IDX_REG) |=>
    ext_index_reg[0] == $past(isa_wdata_i))
    else $error("extended index write lost");
  idle_level_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !strobe_act[0] |-> socket_a_strobe_o == !ctrl_reg[0][gstb_pkg::CTRL_ACT_HIGH_BIT])
    else $error("strobe a idle level wrong");
  idle_level_b_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !strobe_act[1] |-> socket_b_strobe_o == !ctrl_reg[1][gstb_pkg::CTRL_ACT_HIGH_BIT])
    else $error("strobe b idle level wrong");
  write_strobe_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sel_data[0] && ctrl_reg[0][gstb_pkg::CTRL_ON_WRITE_BIT] && !isa_iow_n_i && !isa_aen_i)
    |-> socket_a_strobe_o == ctrl_reg[0][gstb_pkg::CTRL_ACT_HIGH_BIT])
    else $error("write strobe missing");
  read_strobe_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sel_data[1] && ctrl_reg[1][gstb_pkg::CTRL_ON_READ_BIT] && !isa_ior_n_i && !isa_aen_i)
    |-> socket_b_strobe_o == ctrl_reg[1][gstb_pkg::CTRL_ACT_HIGH_BIT])
    else $error("read strobe missing");
  strobe_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (isa_iow_n_i && isa_ior_n_i) |-> !strobe_act[0] && !strobe_act[1])
    else $error("strobe without command");
  open_coll_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!ctrl_reg[1][gstb_pkg::CTRL_TOTEM_BIT] && socket_b_strobe_oe_o) |-> !socket_b_strobe_o)
    else $error("open collector drove high");
  totem_drive_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ctrl_reg[0][gstb_pkg::CTRL_TOTEM_BIT] && ctrl_reg[0][gstb_pkg::CTRL_ON_WRITE_BIT])
    |-> socket_a_strobe_oe_o)
    else $error("totem-pole output not driven");
  pullup_off_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ctrl_reg[0][gstb_pkg::CTRL_ON_WRITE_BIT] || ctrl_reg[0][gstb_pkg::CTRL_ON_READ_BIT] ||
     pullup_dis_i[0]) |-> !socket_a_pullup_o)
    else $error("pull-up a left on");
  pullup_b_off_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ctrl_reg[1][gstb_pkg::CTRL_ON_WRITE_BIT] || ctrl_reg[1][gstb_pkg::CTRL_ON_READ_BIT] ||
     pullup_dis_i[1]) |-> !socket_b_pullup_o)
    else $error("pull-up b left on");
  pullup_on_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!ctrl_reg[0][gstb_pkg::CTRL_ON_WRITE_BIT] && !ctrl_reg[0][gstb_pkg::CTRL_ON_READ_BIT] &&
     !pullup_dis_i[0]) |-> socket_a_pullup_o)
    else $error("pull-up a missing");
  shadow_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sel_data[0] && ctrl_reg[0][gstb_pkg::CTRL_ON_WRITE_BIT] && !isa_ior_n_i && !isa_aen_i)
    |-> isa_rdata_o == shadow_reg[0])
    else $error("shadow not returned");
  shadow_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_commit && sel_data[0] && !suspend_i) |=> shadow_reg[0] == $past(isa_wdata_i))
    else $error("shadow a write lost");
  shadow_rd_mode_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_commit && sel_data[1] && !suspend_i) |=> shadow_reg[1] == $past(isa_wdata_i))
    else $error("shadow b write lost");
  ext_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sel_data[1] && !ctrl_reg[1][gstb_pkg::CTRL_ON_WRITE_BIT] && !isa_ior_n_i && !isa_aen_i)
    |-> isa_rdata_o == ext_rdata_i)
    else $error("external data not returned");
  super_block_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (suspend_i && isa_aen_i) |->
    socket_a_strobe_o == !ctrl_reg[0][gstb_pkg::CTRL_ACT_HIGH_BIT] &&
    socket_b_strobe_o == !ctrl_reg[1][gstb_pkg::CTRL_ACT_HIGH_BIT])
    else $error("strobe in super-suspend");
  suspend_strobe_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (suspend_i && !isa_aen_i && sel_data[1] && !isa_ior_n_i &&
     ctrl_reg[1][gstb_pkg::CTRL_ON_READ_BIT])
    |-> socket_b_strobe_o == ctrl_reg[1][gstb_pkg::CTRL_ACT_HIGH_BIT])
    else $error("strobe lost in suspend");
  shadow_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    suspend_i |=> $stable(shadow_reg[0]) && $stable(shadow_reg[1]))
    else $error("shadow written in suspend");
  index_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_commit && at_index_port) |=> main_index_reg == $past(isa_wdata_i))
    else $error("main index write lost");
  index_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (at_index_port && !isa_ior_n_i && !isa_aen_i) |->
    isa_rdata_oe_o && isa_rdata_o == main_index_reg)
    else $error("main index not returned");
  rdata_quiet_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    isa_ior_n_i |-> !isa_rdata_oe_o)
    else $error("read data driven without read");
endmodule

// File: sim/gstb_ext_model.sv
// external write latch and read buffer hung on the strobe pins
`timescale 1ns/1ps
module gstb_ext_model
#(
  parameter logic [7:0] BUF_VAL = 8'h3c
)
(
  // strobe pins as seen on the board
  input wire logic wr_stb_n_i,
  input wire logic rd_stb_i,
  // system data bus
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [7:0] latch_o
);
  // ---------------------------------------------------------------
  // write latch, cleared at power-up like a reset-tied latch
  // ---------------------------------------------------------------
  initial latch_o = 8'h00;
  always @(posedge wr_stb_n_i) latch_o <= wdata_i;
  // ---------------------------------------------------------------
  // read buffer
  // ---------------------------------------------------------------
  // released buffer shows inverted data so a missing strobe never reads right
  assign rdata_o = rd_stb_i ? BUF_VAL : ~BUF_VAL;
endmodule

// File: sim/gstb_port_bench.sv
// self-checking bench for the general strobe port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module gstb_port_bench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk_i, sys_rst_i, ior_n, iow_n, aen, suspend, a_out, a_oe, a_pu;
  logic b_out, b_oe, b_pu, rdata_oe, pa, pb, ob, roe;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, ext_rdata, latch, r;
  logic [1:0] pu_dis, level;
  int miscompares = 0;
  int checked = 0;
  // open-collector pins need a board pull-up
  tri1 a_pin, b_pin;
  assign a_pin = a_oe ? a_out : 1'bz;
  assign b_pin = b_oe ? b_out : 1'bz;
  gstb_port gstb_port_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .isa_addr_i(addr), .isa_wdata_i(wdata), .isa_ior_n_i(ior_n), .isa_iow_n_i(iow_n),
    .isa_aen_i(aen), .isa_rdata_o(rdata), .isa_rdata_oe_o(rdata_oe),
    .ext_rdata_i(ext_rdata), .suspend_i(suspend), .pullup_dis_i(pu_dis),
    .socket_a_strobe_i(a_pin), .socket_b_strobe_i(b_pin), .socket_a_strobe_o(a_out),
    .socket_a_strobe_oe_o(a_oe), .socket_a_pullup_o(a_pu), .socket_b_strobe_o(b_out),
    .socket_b_strobe_oe_o(b_oe), .socket_b_pullup_o(b_pu), .strobe_pin_level_o(level));
  gstb_ext_model gstb_ext_model_inst (.wr_stb_n_i(a_pin), .rd_stb_i(b_pin),
    .wdata_i(wdata), .rdata_o(ext_rdata), .latch_o(latch));
  // ---------------------------------------------------------------
  // bus cycle tasks
  // ---------------------------------------------------------------
  task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr <= a;
    wdata <= d;
    if (wr) iow_n <= 1'b0;
    else ior_n <= 1'b0;
    @(negedge core_clk_i);
    r = rdata;
    roe = rdata_oe;
    pa = a_pin;
    pb = b_pin;
    ob = b_oe;
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    // address and data held while the write sync catches up
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic sel(input logic [7:0] m, input logic [7:0] x);
    io(1'b1, gstb_pkg::INDEX_PORT_ADDR, m);
    io(1'b1, gstb_pkg::DATA_PORT_ADDR, x);
    io(1'b1, gstb_pkg::INDEX_PORT_ADDR, m + 8'h01);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    sel(gstb_pkg::SOCK_A_EXT_IDX_REG, gstb_pkg::STROBE_CTRL_IDX);
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("ctrl a reset", 8'h00, r) // control at 0bh
    `CHK("pullup a", 1'b1, a_pu) // unconfigured pull-up
    `CHK("pin levels", 2'h3, level) // pulled-up inputs
    pu_dis <= 2'b10;
    @(negedge core_clk_i);
    `CHK("pullup b off", 1'b0, b_pu) // pull-up disable
    pu_dis <= 2'b00;
    $display("test reset done");
  endtask
  task automatic t_readback();
    io(1'b0, gstb_pkg::INDEX_PORT_ADDR, 8'h00);
    `CHK("main index", gstb_pkg::SOCK_A_EXT_DATA_REG, r) // index readback
    `CHK("index read oe", 1'b1, roe) // read data driven
    io(1'b1, gstb_pkg::INDEX_PORT_ADDR, gstb_pkg::SOCK_A_EXT_IDX_REG);
    `CHK("write oe off", 1'b0, roe) // no drive on write
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("ext index a", gstb_pkg::STROBE_CTRL_IDX, r) // extended index readback
    aen <= 1'b1;
    io(1'b1, gstb_pkg::INDEX_PORT_ADDR, gstb_pkg::SOCK_B_EXT_IDX_REG);
    aen <= 1'b0;
    io(1'b0, gstb_pkg::INDEX_PORT_ADDR, 8'h00);
    `CHK("aen write blocked", gstb_pkg::SOCK_A_EXT_IDX_REG, r) // aen refuses cycle
    $display("test readback done");
  endtask
  task automatic t_write_port();
    sel(gstb_pkg::SOCK_A_EXT_IDX_REG, gstb_pkg::STROBE_CTRL_IDX);
    io(1'b1, gstb_pkg::DATA_PORT_ADDR, 8'h14); // reserved bits zero
    `CHK("pullup a strobe", 1'b0, a_pu) // strobe kills pull-up
    `CHK("a totem idle", 1'b1, a_oe) // totem drives high
    sel(gstb_pkg::SOCK_A_EXT_IDX_REG, gstb_pkg::EXT_PORT_DATA_IDX);
    io(1'b1, gstb_pkg::DATA_PORT_ADDR, 8'ha5);
    `CHK("a write pulse", 1'b0, pa) // low during iow
    `CHK("latch", 8'ha5, latch) // latch updated
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("a no read pulse", 1'b1, pa) // no read strobe
    `CHK("a shadow", 8'ha5, r) // shadow readback
    $display("test write port done");
  endtask
  task automatic t_read_port();
    sel(gstb_pkg::SOCK_B_EXT_IDX_REG, gstb_pkg::STROBE_CTRL_IDX);
    io(1'b1, gstb_pkg::DATA_PORT_ADDR, 8'h28); // reserved bits zero
    `CHK("b idle low", 1'b0, b_pin) // active-high idles low
    // pin level passes two sync flops after the late control commit
    repeat (2) @(negedge core_clk_i);
    `CHK("b level", 1'b0, level[1]) // sampled pin level
    sel(gstb_pkg::SOCK_B_EXT_IDX_REG, gstb_pkg::EXT_PORT_DATA_IDX);
    io(1'b1, gstb_pkg::DATA_PORT_ADDR, 8'h77);
    `CHK("b no write pulse", 1'b0, pb) // read strobe only
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("b read pulse", 1'b1, pb) // high during ior
    `CHK("b released", 1'b0, ob) // open-collector high is off
    `CHK("b ext data", 8'h3c, r) // buffer not shadow
    $display("test read port done");
  endtask
  task automatic t_suspend();
    suspend <= 1'b1;
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("b suspend pulse", 1'b1, pb) // works in suspend
    aen <= 1'b1;
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("b super suspend", 1'b0, pb) // blocked by aen
    aen <= 1'b0;
    sel(gstb_pkg::SOCK_A_EXT_IDX_REG, gstb_pkg::EXT_PORT_DATA_IDX);
    io(1'b1, gstb_pkg::DATA_PORT_ADDR, 8'h5a);
    `CHK("a suspend pulse", 1'b0, pa) // clockless strobe
    `CHK("latch suspend", 8'h5a, latch) // latch still written
    suspend <= 1'b0;
    io(1'b0, gstb_pkg::DATA_PORT_ADDR, 8'h00);
    `CHK("a shadow kept", 8'ha5, r) // no shadow in suspend
    $display("test suspend done");
  endtask
  // ---------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    sys_rst_i = 1'b1;
    {ior_n, iow_n, aen, suspend, pu_dis, addr, wdata} = {2'b11, 2'b00, 2'b00, 18'h00000};
    repeat (12) @(negedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_readback();
    t_write_port();
    t_read_port();
    t_suspend();
    complete_run();
  end
  // whole run is a few hundred cycles; far past that means a hang
  initial
  begin
    #20us;
    miscompares++;
    complete_run();
  end
endmodule
